// ---- hw/dmb_pkg.sv ----
// dmb_pkg: constants for the data memory bank addressing block.
// assumes a single core clock shared by decoder, this block and the ram.
package dmb_pkg;
  localparam int DMB_ADDR_W = 12;
  localparam int DMB_FILE_W = 8;
  localparam int DMB_BANK_W = 4;
  localparam int DMB_DATA_W = 8;
  localparam int DMB_NUM_BANKS = 16;
  localparam logic [3:0] DMB_ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] DMB_ACCESS_LO_BANK = 4'h0;
  localparam logic [7:0] DMB_ACCESS_SPLIT = 8'h80;
  localparam logic [7:0] DMB_BSR_RESET = 8'h00;
  localparam logic [3:0] DMB_BSR_IMPL_MASK = 4'hF;
  localparam logic [15:0] DMB_IMPL_BANKS_DEF = 16'h8003;
  localparam logic [7:0] DMB_ZERO_BYTE = 8'h00;
endpackage : dmb_pkg

// ---- hw/dmb_zero_gate.sv ----
// dmb_zero_gate: registered read path that forces zero for unimplemented banks.
// assumes the ram registers the address, then returns data one cycle after its enable.
module dmb_zero_gate
  import dmb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_rd_en,
  input wire logic i_bank_ok,
  input wire logic [DMB_DATA_W-1:0] i_ram_rdata,
  output logic [DMB_DATA_W-1:0] o_rdata,
  output logic o_rvalid
);
  logic [DMB_DATA_W-1:0] rdata_r;
  logic rvalid_r;
  logic ok_r;
  logic pend_r;
  logic ok2_r;
  logic pend2_r;
  // two stages: one for the registered ram address, one for the ram's own read latency
  wire logic [DMB_DATA_W-1:0] gated = ok2_r ? i_ram_rdata : DMB_ZERO_BYTE;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= DMB_ZERO_BYTE;
      rvalid_r <= 1'b0;
      ok_r <= 1'b0;
      pend_r <= 1'b0;
      ok2_r <= 1'b0;
      pend2_r <= 1'b0;
    end else begin
      pend_r <= i_rd_en;
      ok_r <= i_bank_ok;
      pend2_r <= pend_r;
      ok2_r <= ok_r;
      rvalid_r <= pend2_r;
      if (pend2_r) begin
        rdata_r <= gated;
      end
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;

  chk_unimpl_reads_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd_en && !i_bank_ok) |-> ##3 (o_rvalid && o_rdata == DMB_ZERO_BYTE))
    else $error("read of unimplemented bank did not return zero");
endmodule : dmb_zero_gate

// ---- hw/dmb_bank_addr.sv ----
// dmb_bank_addr: data memory address former for direct addressing.
// Contract
// - access window is bank 15 top 128 bytes plus bank 0 bottom 128.
// - the access bit picks bank select register or access window.
// - with access bit zero, low region end is followed by high region.
// - high region maps special function registers without touching bank select.
// - data memory has sixteen banks selectable for direct addressing.
// - bank select bits 3:0 give address bits 11:8 when banked.
// - bank select bits 7:4 read zero, writes to them ignored.
// - unimplemented bank reads return zero, writes are dropped.
// - unimplemented bank access still lets status flags update.
// - each bank is 256 bytes addressed by the 8-bit file field.
// - file-to-file move uses full 12-bit addresses, ignores bank select.
// - load bank literal instruction writes a constant to bank select.
// assumes the decoder presents one request per cycle; ram is synchronous, 1-cycle read.
module dmb_bank_addr
  import dmb_pkg::*;
#(
  parameter logic [DMB_NUM_BANKS-1:0] IMPL_BANKS = DMB_IMPL_BANKS_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic i_access_bit,
  input wire logic [DMB_FILE_W-1:0] i_file,
  input wire logic [DMB_DATA_W-1:0] i_wdata,
  input wire logic i_ffm,
  input wire logic [DMB_ADDR_W-1:0] i_ffm_addr,
  input wire logic i_lbl,
  input wire logic [DMB_DATA_W-1:0] i_lbl_value,
  input wire logic i_bsr_wr,
  input wire logic [DMB_DATA_W-1:0] i_bsr_wdata,
  input wire logic [DMB_DATA_W-1:0] i_ram_rdata,
  output logic [DMB_ADDR_W-1:0] o_ram_addr,
  output logic o_ram_en,
  output logic o_ram_we,
  output logic [DMB_DATA_W-1:0] o_ram_wdata,
  output logic [DMB_DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_flags_en,
  output logic [DMB_DATA_W-1:0] o_bank_select
);
  logic [DMB_BANK_W-1:0] bank_r;
  logic [DMB_BANK_W-1:0] bank_nxt;
  logic [DMB_ADDR_W-1:0] addr_r;
  logic en_r;
  logic we_r;
  logic [DMB_DATA_W-1:0] wdata_r;
  logic flags_r;

  // access window: low half of file field stays in bank 0, high half jumps to bank 15
  wire logic file_hi = i_file >= DMB_ACCESS_SPLIT;
  wire logic [DMB_BANK_W-1:0] access_bank =
    file_hi ? DMB_ACCESS_HI_BANK : DMB_ACCESS_LO_BANK;
  wire logic [DMB_BANK_W-1:0] dir_bank =
    i_access_bit ? bank_r : access_bank;
  wire logic [DMB_ADDR_W-1:0] dir_addr = {dir_bank, i_file};
  wire logic [DMB_ADDR_W-1:0] eff_addr = i_ffm ? i_ffm_addr : dir_addr;
  wire logic [DMB_BANK_W-1:0] eff_bank = eff_addr[DMB_ADDR_W-1 -: DMB_BANK_W];
  wire logic bank_ok = IMPL_BANKS[eff_bank];
  wire logic wr_ok = i_req && i_we && bank_ok;

  // the literal load wins over a plain register write in the same cycle
  always_comb begin
    bank_nxt = bank_r;
    if (i_lbl) begin
      bank_nxt = i_lbl_value[DMB_BANK_W-1:0] & DMB_BSR_IMPL_MASK;
    end else if (i_bsr_wr) begin
      bank_nxt = i_bsr_wdata[DMB_BANK_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_r <= DMB_BSR_RESET[DMB_BANK_W-1:0];
      addr_r <= '0;
      en_r <= 1'b0;
      we_r <= 1'b0;
      wdata_r <= DMB_ZERO_BYTE;
      flags_r <= 1'b0;
    end else begin
      bank_r <= bank_nxt;
      addr_r <= eff_addr;
      en_r <= i_req && bank_ok;
      we_r <= wr_ok;
      wdata_r <= i_wdata;
      flags_r <= i_req;
    end
  end

  dmb_zero_gate u_gate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rd_en(i_req && !i_we),
    .i_bank_ok(bank_ok),
    .i_ram_rdata(i_ram_rdata),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid)
  );

  assign o_ram_addr = addr_r;
  assign o_ram_en = en_r;
  assign o_ram_we = we_r;
  assign o_ram_wdata = wdata_r;
  assign o_flags_en = flags_r;
  assign o_bank_select = {{(DMB_DATA_W-DMB_BANK_W){1'b0}}, bank_r};

  chk_access_low_bank: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && !i_ffm && !i_access_bit && i_file < DMB_ACCESS_SPLIT)
    |=> o_ram_addr == {DMB_ACCESS_LO_BANK, $past(i_file)})
    else $error("access window low half not in bank 0");
  chk_access_high_bank: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && !i_ffm && !i_access_bit && i_file >= DMB_ACCESS_SPLIT)
    |=> o_ram_addr == {DMB_ACCESS_HI_BANK, $past(i_file)})
    else $error("access window high half not in bank 15");
  chk_banked_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && !i_ffm && i_access_bit)
    |=> o_ram_addr == {$past(o_bank_select[DMB_BANK_W-1:0]), $past(i_file)})
    else $error("banked address does not use bank select");
  chk_ffm_full_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && i_ffm) |=> o_ram_addr == $past(i_ffm_addr))
    else $error("file to file move address not taken whole");
  chk_bsr_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_bank_select[DMB_DATA_W-1:DMB_BANK_W] == '0)
    else $error("bank select upper bits not zero");
  chk_lbl_loads: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_lbl |=> o_bank_select[DMB_BANK_W-1:0] == $past(i_lbl_value[DMB_BANK_W-1:0]))
    else $error("load bank literal did not land");
  chk_unimpl_write_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && i_we && !bank_ok) |=> !o_ram_we && !o_ram_en)
    else $error("write to unimplemented bank reached ram");
  chk_flags_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_req |=> o_flags_en)
    else $error("status flag update lost");
endmodule : dmb_bank_addr

// ---- bench/dmb_ram_model.sv ----
// dmb_ram_model: behavioural data ram facing the address former.
// assumes the core clock; read data lands the cycle after a read enable.
module dmb_ram_model
  import dmb_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DMB_ADDR_W-1:0] i_addr,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [DMB_DATA_W-1:0] i_wdata,
  output logic [DMB_DATA_W-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DMB_DATA_W-1:0] mem_r [4096];
  initial o_rdata = 8'h00;
  // outside a read the bus toggles, so stale data never looks right
  always @(posedge i_clk) begin
    if (i_en && i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
    o_rdata <= (i_en && !i_we) ? mem_r[i_addr] : ~o_rdata;
  end
endmodule : dmb_ram_model

// ---- bench/dmb_bank_addr_tb_top.sv ----
// dmb_bank_addr_tb_top: directed bench for the bank address former.
// assumes default implemented banks 0, 1 and 15.
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module dmb_bank_addr_tb_top;
  import dmb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst_n = 0, req = 0, we = 0, ab = 0, ffm = 0, lbl = 0, bwr = 0;
  logic [7:0] file = 0, wd = 0, lv = 0, bwd = 0;
  logic [11:0] fa = 0;
  wire [7:0] rram, wram, rd, bs;
  wire [11:0] addr;
  wire en, rwe, rv, fl;
  int num_errors = 0, comparisons = 0, cyc = 0;
  dmb_bank_addr u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_we(we),
    .i_access_bit(ab), .i_file(file), .i_wdata(wd), .i_ffm(ffm), .i_ffm_addr(fa),
    .i_lbl(lbl), .i_lbl_value(lv), .i_bsr_wr(bwr), .i_bsr_wdata(bwd), .i_ram_rdata(rram),
    .o_ram_addr(addr), .o_ram_en(en), .o_ram_we(rwe), .o_ram_wdata(wram), .o_rdata(rd),
    .o_rvalid(rv), .o_flags_en(fl), .o_bank_select(bs));
  dmb_ram_model u_ram (.i_clk(i_clk), .i_addr(addr), .i_en(en), .i_we(rwe),
    .i_wdata(wram), .o_rdata(rram));
  always #20 i_clk = ~i_clk;
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic setb(input logic l, w, input logic [7:0] v, b, e);
    @(posedge i_clk);
    #1;
    lbl = l;
    bwr = w;
    lv = v;
    bwd = b;
    @(posedge i_clk);
    #1;
    lbl = 0;
    bwr = 0;
    `CHK("bank_select", e, bs)
  endtask : setb
  task automatic acc(input logic w, a, f, input logic [7:0] fi, d, input logic [11:0] x, ea,
      input logic ok, input logic [7:0] er);
    int n;
    @(posedge i_clk);
    #1;
    {req, we, ab, ffm, file, wd, fa} = {1'b1, w, a, f, fi, d, x};
    @(posedge i_clk);
    #1;
    req = 0;
    `CHK("ram_en", ok, en)
    `CHK("ram_we", w & ok, rwe)
    `CHK("flags_en", 1'b1, fl)
    if (ok) `CHK("ram_addr", ea, addr)
    if (ok && w) `CHK("ram_wdata", d, wram)
    n = 0;
    while (!w && rv !== 1'b1 && n < 3) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (!w) `CHK("rdata", er, rd)
  endtask : acc
  task automatic t_bank();
    `CHK("bank_select", 8'h00, bs)
    setb(0, 1, 8'h00, 8'hF1, 8'h01);
    setb(1, 1, 8'h3F, 8'h02, 8'h0F);
  endtask : t_bank
  task automatic t_banked();
    acc(1, 1, 0, 8'h00, 8'hC3, 0, 12'hF00, 1, 0);
    setb(0, 1, 8'h00, 8'h01, 8'h01);
    acc(1, 1, 0, 8'hFF, 8'hA5, 0, 12'h1FF, 1, 0);
    acc(0, 1, 0, 8'hFF, 0, 0, 12'h1FF, 1, 8'hA5);
  endtask : t_banked
  task automatic t_window();
    acc(1, 0, 0, 8'h7F, 8'h11, 0, 12'h07F, 1, 0);
    acc(1, 0, 0, 8'h80, 8'h22, 0, 12'hF80, 1, 0);
    acc(0, 0, 0, 8'h80, 0, 0, 12'hF80, 1, 8'h22);
    `CHK("bank_select", 8'h01, bs)
  endtask : t_window
  task automatic t_unimpl();
    setb(0, 1, 8'h00, 8'h02, 8'h02);
    acc(1, 1, 0, 8'h10, 8'h77, 0, 0, 0, 0);
    acc(0, 1, 0, 8'h10, 0, 0, 0, 0, 8'h00);
  endtask : t_unimpl
  task automatic t_ffm();
    acc(1, 1, 1, 8'h10, 8'h5C, 12'h1AB, 12'h1AB, 1, 0);
    acc(0, 0, 1, 8'h10, 0, 12'h1AB, 12'h1AB, 1, 8'h5C);
  endtask : t_ffm
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_n = 1;
    t_bank();
    t_banked();
    t_window();
    t_unimpl();
    t_ffm();
    end_of_test();
  end
endmodule : dmb_bank_addr_tb_top
